// ==== pse_port_control_pins.sv ====
// Functional notes
// R01: interrupt pin low while any flag set
// R02: fast shutdown active high, deglitched
// R03: shutdown turns off like reset command
// R04: pulse count picks three-bit priority
// R05: reset pin active low, deglitched
// R06: reset turns ports off, clears registers
// R07: internal power-on reset independent of pin
// R08: high port voltage: discharge, 400 ms backoff
// R09: detection uses two probe current levels
// R10: bias resistor except detecting or powered
// R11: turn-on drives gate up
// R12: gate low on supply loss, overcurrent timeout
// R13: gate low on manual shutdown
// R14: fast short turns gate off immediately
// R15: classification may run on ports together
// R16: address from four pulled-up select inputs
// R17: split serial data in and open-drain out
// R18: count pulses, shed ports at or below level
module pse_port_control_pins
  import pse_pkg::*;
#(
  parameter int unsigned BACKOFF_CYC = BACKOFF_CYC_DEF
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst_n, // internal power-on reset, active low
  input wire logic reset_pin_n, // external reset pin, active low
  input wire logic fast_shutdown_in, // fast shutdown pin, active high
  input wire logic [3:0] target_address_select, // address straps
  input wire logic serial_data_in, // serial data input pin
  input wire logic sda_drive_low, // serial engine wants data low
  input wire logic [7:0] reg_addr, // register address from serial engine
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_we, // register write strobe, one cycle
  input wire logic [7:0] int_flags, // interrupt register contents
  input wire logic [23:0] port_prio, // three bits of priority per port
  input wire logic [7:0] port_enable, // software port enables
  input wire logic [7:0] supply_ok, // supplies good per port
  input wire logic [7:0] volt_high, // port above 2.5 V
  input wire logic [7:0] oc_timeout, // overcurrent timeout expired
  input wire logic [7:0] fast_short, // fast overload comparator
  input wire logic [7:0] manual_off, // manual shutdown
  input wire logic [7:0] class_req, // classification in progress
  output logic [7:0] fet_gate_drive, // gate on per port
  output logic [7:0] discharge_en, // discharge resistor per port
  output logic [7:0] probe_lo, // low probe current per port
  output logic [7:0] probe_hi, // high probe current per port
  output logic [7:0] bias_res_en, // sense bias resistor per port
  output logic [7:0] classifying, // classification active per port
  output logic [6:0] target_addr, // captured bus address
  output logic serial_data_sync, // synchronised serial data in
  output logic serial_data_out_oe, // open drain data out, high drives low
  output logic int_oe, // interrupt pin, high drives low
  output logic [2:0] shed_level, // last latched priority level
  output logic reg_clear // registers back to power-up values
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] fsd_s;
    logic [1:0] rst_s;
    logic [1:0] sda_s;
    logic [3:0] sel_s;
    logic [7:0] deg_fsd;
    logic [7:0] deg_rst;
    logic fsd_f;
    logic rst_f;
    logic [3:0] pcnt;
    logic [CNT_W-1:0] gap;
    logic [2:0] level;
    logic [7:0] kill;
    logic [7:0] cmd_kill;
    logic clr;
    logic [6:0] addr;
    logic int_o;
    logic sda_o;
  } top_t;

  top_t q, d;
  port_out_t pout [NUM_PORTS];
  logic [7:0] kill_any;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.fsd_s = {q.fsd_s[0], fast_shutdown_in};
    d.rst_s = {q.rst_s[0], reset_pin_n};
    d.sda_s = {q.sda_s[0], serial_data_in}; // [R17]
    // straps are pins too, but they get only one stage (sel_s) before the address register
    d.sel_s = target_address_select; // [R16]
    d.kill = '0;
    d.cmd_kill = '0;
    // filters need a stable level for the full window; shorter pulses vanish
    if (q.fsd_s[1] == q.fsd_f) begin
      d.deg_fsd = '0;
    end else if (q.deg_fsd == 8'(DEGLITCH_CYC - 1)) begin
      d.deg_fsd = '0;
      d.fsd_f = q.fsd_s[1]; // [R02]
    end else begin
      d.deg_fsd = q.deg_fsd + 8'h01;
    end
    if (q.rst_s[1] == q.rst_f) begin
      d.deg_rst = '0;
    end else if (q.deg_rst == 8'(DEGLITCH_CYC - 1)) begin
      d.deg_rst = '0;
      d.rst_f = q.rst_s[1]; // [R05]
    end else begin
      d.deg_rst = q.deg_rst + 8'h01;
    end
    // count accepted rising pulses; a quiet gap closes the sequence
    if (d.fsd_f && !q.fsd_f) begin
      if (q.pcnt != 4'h8) begin
        d.pcnt = q.pcnt + 4'h1; // [R04] [R18]
      end
      d.gap = CNT_W'(PULSE_GAP_CYC);
    end else if (q.gap != '0 && !q.fsd_f) begin
      d.gap = q.gap - 1'b1;
      if (q.gap == CNT_W'(1) && q.pcnt != 4'h0) begin
        d.level = 3'(q.pcnt - 4'h1); // [R04] [R18]
        d.pcnt = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
          d.kill[i] = (port_prio[i*3 +: 3] <= 3'(q.pcnt - 4'h1)); // [R18] [R03]
        end
      end
    end
    if (reg_we && reg_addr == PORT_RESET_COMMAND_ADDR) begin
      d.cmd_kill = reg_wdata; // [R03]
    end
    d.clr = !q.rst_f; // [R06]
    d.addr = {3'h0, q.sel_s}; // [R16]
    d.int_o = |int_flags; // [R01]
    d.sda_o = sda_drive_low; // [R17]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin // [R07]
      q <= '0;
      q.fsd_s <= 2'h0;
      q.rst_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.rst_f <= 1'b1;
      q.level <= PRIO_RESET;
      q.clr <= 1'b1;
    end else if (q.clr) begin
      q <= d; // [R06]
      q.level <= PRIO_RESET;
      q.pcnt <= '0;
      q.gap <= '0;
      q.kill <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // ports
  // ----------------------------------------
  assign kill_any = q.kill | q.cmd_kill;

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    pse_port_channel #(
      .BACKOFF_CYC(BACKOFF_CYC)
    ) u_ch (
      .mclk(mclk),
      .clr(q.clr || !rst_n), // [R06]
      .kill(kill_any[g]),
      .pin('{enable: port_enable[g], supply_ok: supply_ok[g], volt_high: volt_high[g],
             oc_timeout: oc_timeout[g], fast_short: fast_short[g],
             manual_off: manual_off[g], class_req: class_req[g]}),
      .pout(pout[g])
    );
    assign fet_gate_drive[g] = pout[g].gate_on;
    assign discharge_en[g] = pout[g].discharge_en;
    assign probe_lo[g] = pout[g].probe_lo;
    assign probe_hi[g] = pout[g].probe_hi;
    assign bias_res_en[g] = pout[g].bias_res_en;
    assign classifying[g] = pout[g].classifying;
  end

  assign target_addr = q.addr;
  assign serial_data_sync = q.sda_s[1];
  assign serial_data_out_oe = q.sda_o;
  assign int_oe = q.int_o;
  assign shed_level = q.level;
  assign reg_clear = q.clr;

endmodule

// ==== pse_pkg.sv ====
package pse_pkg;

  // ----------------------------------------
  // sizes and timing
  // ----------------------------------------
  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned DEGLITCH_NS = 2000;
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PULSE_GAP_US = 100;
  localparam int unsigned PULSE_GAP_CYC = PULSE_GAP_US * (CLK_HZ / 1000000);
  localparam int unsigned BACKOFF_MS = 400;
  localparam int unsigned BACKOFF_CYC_DEF = BACKOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned DETECT_STEP_US = 1000;
  localparam int unsigned DETECT_STEP_CYC = DETECT_STEP_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W = 24;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam logic [7:0] PORT_RESET_COMMAND_ADDR = 8'h1A;
  localparam logic [2:0] PRIO_RESET = 3'h0;

  // ----------------------------------------
  // port state
  // ----------------------------------------
  typedef enum logic [4:0] {
    P_IDLE    = 5'h01,
    P_BACKOFF = 5'h02,
    P_DETECT  = 5'h04,
    P_CLASS   = 5'h08,
    P_ON      = 5'h10
  } port_state_t;

  typedef struct packed {
    logic enable;
    logic supply_ok;
    logic volt_high;
    logic oc_timeout;
    logic fast_short;
    logic manual_off;
    logic class_req;
  } port_in_t;

  typedef struct packed {
    logic gate_on;
    logic discharge_en;
    logic probe_lo;
    logic probe_hi;
    logic bias_res_en;
    logic classifying;
  } port_out_t;

endpackage

// ==== pse_port_channel.sv ====
module pse_port_channel
  import pse_pkg::*;
#(
  parameter int unsigned BACKOFF_CYC = BACKOFF_CYC_DEF
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic clr, // synchronous clear, active high
  input wire logic kill, // shutdown request, one cycle
  input wire port_in_t pin, // per port conditions
  output port_out_t pout // per port drive
);

  typedef struct packed {
    port_state_t st;
    logic [CNT_W-1:0] cnt;
    port_out_t o;
  } ch_t;

  ch_t q, d;

  always_comb begin
    d = q;
    d.o = '0;
    d.cnt = (q.cnt == '0) ? q.cnt : q.cnt - 1'b1;
    unique case (q.st)
      P_IDLE: begin
        if (pin.enable) begin
          if (pin.volt_high) begin
            d.st = P_BACKOFF; // [R08]
            d.cnt = CNT_W'(BACKOFF_CYC);
          end else begin
            d.st = P_DETECT;
            d.cnt = CNT_W'(2 * DETECT_STEP_CYC);
          end
        end
      end
      P_BACKOFF: begin
        d.o.discharge_en = 1'b1; // [R08]
        if (q.cnt == '0) begin
          d.st = P_DETECT;
          d.cnt = CNT_W'(2 * DETECT_STEP_CYC);
        end
      end
      P_DETECT: begin
        // two probe levels, one per half of the window
        d.o.probe_lo = (q.cnt > CNT_W'(DETECT_STEP_CYC)); // [R09]
        d.o.probe_hi = ~d.o.probe_lo; // [R09]
        if (q.cnt == '0) begin
          d.st = P_CLASS;
        end
      end
      P_CLASS: begin
        d.o.classifying = 1'b1; // [R15]
        if (!pin.class_req) begin
          d.st = P_ON;
        end
      end
      P_ON: begin
        d.o.gate_on = 1'b1; // [R11]
      end
      default: begin
        d.st = P_IDLE;
      end
    endcase
    // the last detect cycle still drives a probe while the state already reads class
    d.o.bias_res_en = (d.st != P_DETECT) && (d.st != P_ON) && !d.o.probe_lo &&
                      !d.o.probe_hi; // [R10]
    // any fault or shutdown pulls the gate low at once
    if (kill || !pin.supply_ok || pin.oc_timeout || pin.fast_short || pin.manual_off ||
        !pin.enable) begin // [R12] [R13] [R14] [R03]
      d.st = P_IDLE;
      d.cnt = '0;
      d.o = '0;
      d.o.bias_res_en = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      q <= '{st: P_IDLE, cnt: '0, o: '{bias_res_en: 1'b1, default: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign pout = q.o;

endmodule

// ==== pse_pins_asserts.sv ====
module pse_pins_asserts
  import pse_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic [3:0] target_address_select, // straps
  input wire logic sda_drive_low, // data low request
  input wire logic [7:0] int_flags, // flags
  input wire logic [7:0] supply_ok, // supplies
  input wire logic [7:0] oc_timeout, // overcurrent
  input wire logic [7:0] fast_short, // short
  input wire logic [7:0] manual_off, // manual off
  input wire logic [7:0] fet_gate_drive, // gates
  input wire logic [7:0] probe_lo, // low probe
  input wire logic [7:0] probe_hi, // high probe
  input wire logic [7:0] bias_res_en, // bias
  input wire logic [6:0] target_addr, // address
  input wire logic serial_data_out_oe, // data out
  input wire logic int_oe, // interrupt
  input wire logic reg_clear // clear
);
  // ----
  // checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_int_pin_follow: assert property (1'b1 |=> int_oe == |$past(int_flags))
    else $error("int pin wrong");
  a_addr_from_straps: assert property (
    $past(rst_n) |=> target_addr == {3'h0, $past(target_address_select, 2)})
    else $error("address wrong");
  a_sda_out_follow: assert property (
    1'b1 |=> serial_data_out_oe == $past(sda_drive_low))
    else $error("data out wrong");
  a_gate_supply_low: assert property ((fet_gate_drive & $past(~supply_ok, 2)) == 8'h00)
    else $error("gate on, supply low");
  a_gate_oc_timeout: assert property ((fet_gate_drive & $past(oc_timeout, 2)) == 8'h00)
    else $error("gate on after timeout");
  a_gate_fast_short: assert property ((fet_gate_drive & $past(fast_short, 2)) == 8'h00)
    else $error("gate on at short");
  a_gate_manual_off: assert property ((fet_gate_drive & $past(manual_off, 2)) == 8'h00)
    else $error("gate on at manual off");
  a_probe_one_level: assert property ((probe_lo & probe_hi) == 8'h00)
    else $error("both probes on");
  a_bias_res_off: assert property (
    ((fet_gate_drive | probe_lo | probe_hi) & bias_res_en) == 8'h00)
    else $error("bias on while probing or on");
  a_reset_values: assert property ($rose(rst_n) |->
    reg_clear && fet_gate_drive == 8'h00 && bias_res_en == 8'hFF)
    else $error("reset values wrong");
endmodule

bind pse_port_control_pins pse_pins_asserts u_chk (.mclk(mclk), .rst_n(rst_n),
  .target_address_select(target_address_select), .sda_drive_low(sda_drive_low),
  .int_flags(int_flags), .supply_ok(supply_ok), .oc_timeout(oc_timeout),
  .fast_short(fast_short), .manual_off(manual_off), .fet_gate_drive(fet_gate_drive),
  .probe_lo(probe_lo), .probe_hi(probe_hi), .bias_res_en(bias_res_en),
  .target_addr(target_addr), .serial_data_out_oe(serial_data_out_oe),
  .int_oe(int_oe), .reg_clear(reg_clear));

// ==== pse_host_model.sv ====
module pse_host_model (
  input wire logic mclk, // clock
  output logic [7:0] reg_addr, // address
  output logic [7:0] reg_wdata, // data
  output logic reg_we, // strobe
  output logic sda_drive_low // data low request
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_addr, reg_wdata, reg_we, sda_drive_low} = 18'h0;
  // ----
  // host accesses
  // ----
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    {reg_addr, reg_wdata, reg_we} = {a, d, 1'b1};
    @(posedge mclk) #1;
    // released lines show no stale value
    {reg_addr, reg_wdata, reg_we} = {~a, ~d, 1'b0};
  endtask
  task drv_low(input logic b);
    sda_drive_low = b;
  endtask
endmodule

// ==== testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pse_pkg::*;
  logic mclk, rst_n, rpin_n, fsd, sdi, sds, sdo, intoe, rc, we, sdl;
  logic [3:0] sel;
  logic [7:0] flags, en, sok, vh, oc, fs, mo, cr, ra, rw;
  logic [7:0] gate, dis, plo, phi, bias, cls, hs, cs;
  logic [23:0] prio;
  logic [6:0] taddr;
  logic [2:0] lvl;
  int n_fail, samples_checked, exp_gate;
  int pw[$] = '{60, 10, 60, 60};
  pse_host_model u_host (.mclk(mclk), .reg_addr(ra), .reg_wdata(rw), .reg_we(we),
    .sda_drive_low(sdl));
  pse_port_control_pins #(.BACKOFF_CYC(100)) u_pse_port_control_pins (.mclk(mclk),
    .rst_n(rst_n), .reset_pin_n(rpin_n), .fast_shutdown_in(fsd), .target_address_select(sel),
    .serial_data_in(sdi), .sda_drive_low(sdl), .reg_addr(ra), .reg_wdata(rw), .reg_we(we),
    .int_flags(flags), .port_prio(prio), .port_enable(en), .supply_ok(sok), .volt_high(vh),
    .oc_timeout(oc), .fast_short(fs), .manual_off(mo), .class_req(cr),
    .fet_gate_drive(gate), .discharge_en(dis), .probe_lo(plo), .probe_hi(phi),
    .bias_res_en(bias), .classifying(cls), .target_addr(taddr), .serial_data_sync(sds),
    .serial_data_out_oe(sdo), .int_oe(intoe), .shed_level(lvl), .reg_clear(rc));
  // ----
  // helpers
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #3000000;
    n_fail++;
    report_and_stop();
  end
  // ----
  // scenarios
  // ----
  initial begin
    {rst_n, rpin_n, fsd, sdi, sel} = 8'h5F;
    {flags, en, sok, vh, oc, fs, mo, cr} = 64'h0000FF0000000000;
    prio = 24'hFAC688;
    {n_fail, samples_checked, hs, cs} = 0;
    exp_gate = $urandom(34641);
    cyc(8);
    rst_n = 1;
    chk(bias, 8'hFF);
    for (int i = 0; i < 100 && rc !== 1'b0; i++) cyc(1);
    chk(rc, 0);
    repeat (6) begin
      sel = $urandom;
      sdi = $urandom;
      flags = $urandom_range(0, 2) == 0 ? 8'h00 : 8'($urandom);
      u_host.drv_low($urandom);
      cyc(3);
      chk(taddr, {3'h0, sel});
      chk(intoe, |flags);
      chk({sds, sdo}, {sdi, sdl});
    end
    {vh, en, cr} = 24'h02FFFF;
    cyc(5);
    chk({dis[1], plo[1:0]}, 3'h5);
    vh = 0;
    for (int i = 0; i < 45000 && gate !== 8'hFF; i++) begin
      cyc(1);
      hs |= phi;
      cs |= cls;
      if (cs == 8'hFF) cr = 0;
    end
    exp_gate = 8'hFF;
    chk({hs, cs}, 16'hFFFF);
    chk({gate, bias}, {exp_gate[7:0], 8'h00});
    u_host.wr(8'h1B, 8'hF0);
    u_host.wr(8'h1A, 8'h03);
    cyc(3);
    exp_gate &= 8'hFC;
    chk(gate, exp_gate);
    {sok, oc, fs, mo} = 32'hEF204080;
    cyc(3);
    exp_gate &= 8'h0F;
    chk(gate, exp_gate);
    foreach (pw[i]) begin
      fsd = 1;
      cyc(pw[i]);
      fsd = 0;
      cyc(60);
    end
    cyc(2100);
    exp_gate &= 8'hF8;
    chk(lvl, 2);
    chk(gate, exp_gate);
    rpin_n = 0;
    cyc(10);
    rpin_n = 1;
    cyc(60);
    chk(rc, 0);
    rpin_n = 0;
    cyc(60);
    chk({rc, gate, lvl}, 12'h800);
    rpin_n = 1;
    report_and_stop();
  end
endmodule
